//--- common/sss_pkg.sv
// package of constants and types for the servo stop sequencer
package sss_pkg;
  localparam int          SSS_SEL_W        = 4;
  localparam int          SSS_TORQ_W       = 16;
  localparam int          SSS_SPEED_W      = 16;
  localparam int          SSS_TIME_W       = 16;
  localparam int          SSS_CLK_HZ       = 50000000;
  localparam int          SSS_TICK_US      = 1000;
  localparam int          SSS_TICK_CYC     = (SSS_CLK_HZ / 1000000) * SSS_TICK_US;
  localparam int          SSS_PRESC_W      = 16;
  localparam logic [3:0]  SSS_SEL_RST      = 4'h0;
  localparam logic [15:0] SSS_TORQ_RST     = 16'h0000;
  localparam logic [15:0] SSS_TIME_RST     = 16'h0000;
  localparam int          SSS_SEL_POST_BIT = 0;
  localparam int          SSS_SEL_METH_LSB = 1;
  localparam int          SSS_SEL_HOLD_BIT = 3;
  localparam logic        SSS_BRAKE_ENGAGE = 1'b0;
  localparam logic        SSS_BRAKE_FREE   = 1'b1;

  typedef enum logic [1:0] {
    SSS_METH_SERVO = 2'b00,
    SSS_METH_FREE  = 2'b01,
    SSS_METH_DYN   = 2'b10
  } sss_meth_t;

  typedef enum logic [1:0] {
    SSS_POST_FREE = 2'b00,
    SSS_POST_DYN  = 2'b01,
    SSS_POST_HOLD = 2'b10
  } sss_post_t;

  typedef enum logic [2:0] {
    SSS_ST_IDLE  = 3'b000,
    SSS_ST_RUN   = 3'b001,
    SSS_ST_DECEL = 3'b010,
    SSS_ST_STOP  = 3'b011
  } sss_state_t;
endpackage

//--- common/sss_sel_if.sv
// interface carrying the decoded stop selection between modules
`timescale 1ns/1ps
interface sss_sel_if;
  import sss_pkg::*;
  sss_meth_t meth;
  sss_post_t post;
  modport src (output meth, output post);
  modport dst (input meth, input post);
endinterface

//--- hdl/sss_sel_decode.sv
// decoder from a stop selection setting to method and post-stop state
`timescale 1ns/1ps
module sss_sel_decode
  import sss_pkg::*;
(
  input  wire logic [SSS_SEL_W-1:0] sel_i,
  input  wire logic                 hold_ok_i,
  sss_sel_if.src                    sel_if
);
  logic [1:0] meth_code;

  always_comb begin
    meth_code = sel_i[SSS_SEL_METH_LSB +: 2];
    case (meth_code)
      2'b00:   sel_if.meth = SSS_METH_SERVO;
      2'b01:   sel_if.meth = SSS_METH_FREE;
      2'b10:   sel_if.meth = SSS_METH_DYN;
      default: sel_if.meth = SSS_METH_DYN;
    endcase
    // hold only offered for disable stops; alarm select always gives free or dyn
    if (sel_i[SSS_SEL_HOLD_BIT] && hold_ok_i) begin
      sel_if.post = SSS_POST_HOLD;
    end else if (sel_i[SSS_SEL_POST_BIT]) begin
      sel_if.post = SSS_POST_DYN;
    end else begin
      sel_if.post = SSS_POST_FREE;
    end
  end
endmodule

//--- hdl/sss_decel_timer.sv
// deceleration interval timer in millisecond ticks
`timescale 1ns/1ps
module sss_decel_timer
  import sss_pkg::*;
#(
  parameter int TICK_CYC = SSS_TICK_CYC
)
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  start_i,
  input  wire logic [SSS_TIME_W-1:0] limit_i,
  output logic                       expired_o
);
  logic [SSS_PRESC_W-1:0] presc_r, presc_nxt;
  logic [SSS_TIME_W-1:0]  ms_r, ms_nxt;
  logic                   exp_r, exp_nxt;

  always_comb begin
    presc_nxt = presc_r;
    ms_nxt    = ms_r;
    exp_nxt   = exp_r;
    if (start_i) begin
      presc_nxt = '0;
      ms_nxt    = '0;
      exp_nxt   = (limit_i == '0);
    end else if (!exp_r) begin
      if (presc_r == SSS_PRESC_W'(TICK_CYC - 1)) begin
        presc_nxt = '0;
        ms_nxt    = ms_r + 1'b1;
        if (ms_r + 1'b1 >= limit_i) begin
          exp_nxt = 1'b1;
        end
      end else begin
        presc_nxt = presc_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc_r <= '0;
      ms_r    <= '0;
      exp_r   <= 1'b0;
    end else begin
      presc_r <= presc_nxt;
      ms_r    <= ms_nxt;
      exp_r   <= exp_nxt;
    end
  end

  assign expired_o = exp_r;
endmodule

//--- hdl/sss_stop_seq.sv
// servo stop sequencer top: stop method and brake output; post-stop select is registered but changes no output
`timescale 1ns/1ps
module sss_stop_seq
  import sss_pkg::*;
#(
  parameter int TICK_CYC = SSS_TICK_CYC
)
(
  input  wire logic                   CLK_SYS_I,
  input  wire logic                   RST_I,
  input  wire logic                   INIT_DONE_I,
  input  wire logic                   MAIN_POWER_OK_I,
  input  wire logic                   ENABLE_I,
  input  wire logic                   ALARM_I,
  input  wire logic [SSS_SEL_W-1:0]   DISABLE_STOP_SELECT_I,
  input  wire logic [SSS_SEL_W-1:0]   ALARM_STOP_SELECT_I,
  input  wire logic [SSS_TORQ_W-1:0]  STOP_TORQUE_LIMIT_I,
  input  wire logic [SSS_TIME_W-1:0]  STOP_TIME_LIMIT_I,
  input  wire logic [SSS_SPEED_W-1:0] STOP_SPEED_THRESHOLD_I,
  input  wire logic [SSS_SPEED_W-1:0] MOTOR_SPEED_I,
  output logic                        SERVO_READY_STATUS_O,
  output logic                        SERVO_ENABLED_STATUS_O,
  output logic                        POWER_ON_O,
  output logic                        REVERSE_BRAKE_O,
  output logic [SSS_TORQ_W-1:0]       TORQUE_LIMIT_O,
  output logic                        DYN_BRAKE_O,
  output logic                        BRAKE_RELEASE_SIGNAL_O,
  output logic                        BRAKE_ENGAGE_SIGNAL_O,
  output logic                        STOPPING_O,
  output logic                        ALARM_STOP_O
);
  sss_sel_if dis_sel ();
  sss_sel_if alm_sel ();

  sss_state_t             state_r, state_nxt;
  sss_meth_t              meth_r, meth_nxt;
  sss_post_t              post_r, post_nxt;
  logic                   alm_r, alm_nxt;
  logic                   ready_r, ready_nxt;
  logic                   en_st_r, en_st_nxt;
  logic                   pwr_r, pwr_nxt;
  logic                   rev_r, rev_nxt;
  logic [SSS_TORQ_W-1:0]  torq_r, torq_nxt;
  logic                   dyn_r, dyn_nxt;
  logic                   rel_r, rel_nxt;
  logic                   eng_r, eng_nxt;
  logic                   stp_r, stp_nxt;
  logic                   timer_start;
  logic                   timer_exp;
  logic                   slow;
  logic                   decel_done;
  logic                   go_run;

  sss_sel_decode u_dis_dec (
    .sel_i     (DISABLE_STOP_SELECT_I),
    .hold_ok_i (1'b1),
    .sel_if    (dis_sel.src)
  );

  // alarm path cannot select holding, so only six sequences exist
  sss_sel_decode u_alm_dec (
    .sel_i     (ALARM_STOP_SELECT_I),
    .hold_ok_i (1'b0),
    .sel_if    (alm_sel.src)
  );

  sss_decel_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .clk_i     (CLK_SYS_I),
    .rst_i     (RST_I),
    .start_i   (timer_start),
    .limit_i   (STOP_TIME_LIMIT_I),
    .expired_o (timer_exp)
  );

  assign slow       = (MOTOR_SPEED_I < STOP_SPEED_THRESHOLD_I);
  assign decel_done = timer_exp || slow;
  assign go_run     = ENABLE_I && !ALARM_I && ready_r;

  always_comb begin
    state_nxt   = state_r;
    meth_nxt    = meth_r;
    post_nxt    = post_r;
    alm_nxt     = alm_r;
    timer_start = 1'b0;
    ready_nxt   = INIT_DONE_I && MAIN_POWER_OK_I;
    case (state_r)
      SSS_ST_IDLE: begin
        if (go_run) begin
          state_nxt = SSS_ST_RUN;
        end
      end
      SSS_ST_RUN: begin
        if (ALARM_I || !ready_r) begin
          state_nxt   = SSS_ST_DECEL;
          meth_nxt    = alm_sel.meth;
          post_nxt    = alm_sel.post;
          alm_nxt     = 1'b1;
          timer_start = 1'b1;
        end else if (!ENABLE_I) begin
          state_nxt   = SSS_ST_DECEL;
          meth_nxt    = dis_sel.meth;
          post_nxt    = dis_sel.post;
          alm_nxt     = 1'b0;
          timer_start = 1'b1;
        end
      end
      SSS_ST_DECEL: begin
        if (ALARM_I && !alm_r) begin
          // timer keeps running; interval is not restarted by the switch
          meth_nxt = alm_sel.meth;
          post_nxt = alm_sel.post;
          alm_nxt  = 1'b1;
        end
        if (decel_done) begin
          state_nxt = SSS_ST_STOP;
        end
      end
      SSS_ST_STOP: begin
        if (ALARM_I && !alm_r) begin
          post_nxt = alm_sel.post;
          alm_nxt  = 1'b1;
        end
        if (!ENABLE_I && !ALARM_I) begin
          state_nxt = SSS_ST_IDLE;
          alm_nxt   = 1'b0;
        end
      end
      default: begin
        state_nxt = SSS_ST_IDLE;
      end
    endcase
  end

  always_comb begin
    en_st_nxt = 1'b0;
    pwr_nxt   = 1'b0;
    rev_nxt   = 1'b0;
    torq_nxt  = '0;
    dyn_nxt   = 1'b0;
    rel_nxt   = SSS_BRAKE_ENGAGE;
    case (state_nxt)
      SSS_ST_RUN: begin
        en_st_nxt = 1'b1;
        pwr_nxt   = 1'b1;
        rel_nxt   = SSS_BRAKE_FREE;
      end
      SSS_ST_DECEL: begin
        // brake kept released while the rotor still turns
        rel_nxt = SSS_BRAKE_FREE;
        case (meth_nxt)
          SSS_METH_SERVO: begin
            pwr_nxt  = 1'b1;
            rev_nxt  = 1'b1;
            torq_nxt = STOP_TORQUE_LIMIT_I;
          end
          SSS_METH_FREE: begin
            pwr_nxt = 1'b0;
          end
          SSS_METH_DYN: begin
            dyn_nxt = 1'b1;
          end
          default: begin
            dyn_nxt = 1'b1;
          end
        endcase
      end
      SSS_ST_STOP: begin
        // dynamic braking off and brake engaged once decel ends, by time limit or low speed
        dyn_nxt = 1'b0;
        rel_nxt = SSS_BRAKE_ENGAGE;
        case (post_nxt)
          SSS_POST_DYN:  dyn_nxt = 1'b0;
          SSS_POST_FREE: dyn_nxt = 1'b0;
          SSS_POST_HOLD: rel_nxt = SSS_BRAKE_ENGAGE;
          default:       dyn_nxt = 1'b0;
        endcase
      end
      default: begin
        rel_nxt = SSS_BRAKE_ENGAGE;
      end
    endcase
    eng_nxt = ~rel_nxt;
    stp_nxt = (state_nxt == SSS_ST_DECEL);
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      state_r <= SSS_ST_IDLE;
      meth_r  <= SSS_METH_DYN;
      post_r  <= SSS_POST_FREE;
      alm_r   <= 1'b0;
      ready_r <= 1'b0;
      en_st_r <= 1'b0;
      pwr_r   <= 1'b0;
      rev_r   <= 1'b0;
      torq_r  <= SSS_TORQ_RST;
      dyn_r   <= 1'b0;
      rel_r   <= SSS_BRAKE_ENGAGE;
    end else begin
      state_r <= state_nxt;
      meth_r  <= meth_nxt;
      post_r  <= post_nxt;
      alm_r   <= alm_nxt;
      ready_r <= ready_nxt;
      en_st_r <= en_st_nxt;
      pwr_r   <= pwr_nxt;
      rev_r   <= rev_nxt;
      torq_r  <= torq_nxt;
      dyn_r   <= dyn_nxt;
      rel_r   <= rel_nxt;
    end
  end

  // engage mirrors release, so the pair never shows one level
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      eng_r <= ~SSS_BRAKE_ENGAGE;
      stp_r <= 1'b0;
    end else begin
      eng_r <= eng_nxt;
      stp_r <= stp_nxt;
    end
  end

  assign BRAKE_ENGAGE_SIGNAL_O  = eng_r;
  assign STOPPING_O             = stp_r;

  assign SERVO_READY_STATUS_O   = ready_r;
  assign SERVO_ENABLED_STATUS_O = en_st_r;
  assign POWER_ON_O             = pwr_r;
  assign REVERSE_BRAKE_O        = rev_r;
  assign TORQUE_LIMIT_O         = torq_r;
  assign DYN_BRAKE_O            = dyn_r;
  assign BRAKE_RELEASE_SIGNAL_O = rel_r;
  assign ALARM_STOP_O           = alm_r;
endmodule

//--- tb/sss_stop_seq_sva.sv
// checker for the servo stop sequencer
`timescale 1ns/1ps
module sss_stop_seq_sva
  import sss_pkg::*;
#(
  parameter int TICK_CYC = SSS_TICK_CYC
)
(
  input wire logic                   CLK_SYS_I,
  input wire logic                   RST_I,
  input wire logic                   INIT_DONE_I,
  input wire logic                   MAIN_POWER_OK_I,
  input wire logic                   ENABLE_I,
  input wire logic                   ALARM_I,
  input wire logic [SSS_TORQ_W-1:0]  STOP_TORQUE_LIMIT_I,
  input wire logic [SSS_SPEED_W-1:0] STOP_SPEED_THRESHOLD_I,
  input wire logic [SSS_SPEED_W-1:0] MOTOR_SPEED_I,
  input wire logic                   SERVO_READY_STATUS_O,
  input wire logic                   SERVO_ENABLED_STATUS_O,
  input wire logic                   POWER_ON_O,
  input wire logic                   REVERSE_BRAKE_O,
  input wire logic [SSS_TORQ_W-1:0]  TORQUE_LIMIT_O,
  input wire logic                   DYN_BRAKE_O,
  input wire logic                   BRAKE_RELEASE_SIGNAL_O,
  input wire logic                   BRAKE_ENGAGE_SIGNAL_O,
  input wire logic                   STOPPING_O,
  input wire logic                   ALARM_STOP_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  sequence s_dis_req;
    SERVO_ENABLED_STATUS_O && !ENABLE_I && !ALARM_I && SERVO_READY_STATUS_O
      && INIT_DONE_I && MAIN_POWER_OK_I;
  endsequence
  sequence s_dis_decel;
    STOPPING_O && !ALARM_STOP_O && !SERVO_ENABLED_STATUS_O;
  endsequence
  a_dis_select: assert property (s_dis_req |=> s_dis_decel)
    else $error("disable stop not started");
  a_alarm_sel: assert property ($rose(STOPPING_O) && $past(ALARM_I) |-> ALARM_STOP_O)
    else $error("alarm stop without alarm select");
  a_ready_follow: assert property ((INIT_DONE_I && MAIN_POWER_OK_I) [*2] |-> SERVO_READY_STATUS_O)
    else $error("ready missing");
  a_ready_gate: assert property (!(INIT_DONE_I && MAIN_POWER_OK_I) |=> !SERVO_READY_STATUS_O)
    else $error("ready without init or power");
  a_run_entry: assert property ($rose(SERVO_ENABLED_STATUS_O) |->
    $past(ENABLE_I) && !$past(ALARM_I) && $past(SERVO_READY_STATUS_O))
    else $error("enabled without request");
  a_run_levels: assert property (SERVO_ENABLED_STATUS_O |-> POWER_ON_O && BRAKE_RELEASE_SIGNAL_O)
    else $error("running with brake or no power");
  a_brake_pair: assert property (BRAKE_ENGAGE_SIGNAL_O != BRAKE_RELEASE_SIGNAL_O)
    else $error("brake signals not complementary");
  a_torque_lim: assert property (TORQUE_LIMIT_O == (REVERSE_BRAKE_O ? STOP_TORQUE_LIMIT_I : '0))
    else $error("torque limit wrong");
  a_dyn_decel: assert property (DYN_BRAKE_O |-> STOPPING_O && !POWER_ON_O)
    else $error("dyn brake outside decel");
  a_speed_end: assert property (STOPPING_O && MOTOR_SPEED_I < STOP_SPEED_THRESHOLD_I |=> !STOPPING_O)
    else $error("decel not ended by speed");
  a_decel_end: assert property ($fell(STOPPING_O) |-> !DYN_BRAKE_O && BRAKE_ENGAGE_SIGNAL_O)
    else $error("brake not engaged at decel end");
endmodule
bind sss_stop_seq sss_stop_seq_sva #(.TICK_CYC(TICK_CYC)) sss_stop_seq_sva_i (.*);

//--- tb/sss_motor_model.sv
// behavioural motor, dynamic brake and power stage feeding speed back
`timescale 1ns/1ps
module sss_motor_model
  import sss_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   power_on_i,
  input  wire logic                   reverse_brake_i,
  input  wire logic                   dyn_brake_i,
  output logic      [SSS_SPEED_W-1:0] speed_o
);
  logic [SSS_SPEED_W-1:0] speed_r;
  logic [SSS_SPEED_W-1:0] speed_nxt;
  always_comb begin
    speed_nxt = speed_r;
    if (power_on_i && !reverse_brake_i) begin
      speed_nxt = 16'h03E8;
    end else if (reverse_brake_i || dyn_brake_i) begin
      speed_nxt = (speed_r > 16'h0032) ? speed_r - 16'h0032 : 16'h0000;
    end else if (speed_r != 16'h0000) begin
      // coasting is slow, so only the time limit can end it
      speed_nxt = speed_r - 16'h0001;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      speed_r <= 16'h0000;
    end else begin
      speed_r <= speed_nxt;
    end
  end
  assign speed_o = speed_r;
endmodule

//--- tb/sss_stop_seq_tb_top.sv
// self-checking bench for the servo stop sequencer
`timescale 1ns/1ps
module sss_stop_seq_tb_top;
  import sss_pkg::*;
  localparam int          TCK  = 2;
  localparam logic [15:0] TLIM = 16'h0014;
  localparam logic [15:0] TQ   = 16'h0123;
  // row: alarm, select(4), power on, reverse brake, dyn brake
  localparam logic [7:0]  ROWS [10] = '{8'h46, 8'h18, 8'h31, 8'h8E, 8'h86,
                                        8'h90, 8'h98, 8'hA1, 8'hA9, 8'hF1};
  logic        clk, rst, ini, mpw, ena, alm;
  logic [3:0]  dsel, asel;
  logic [15:0] spd, tq;
  logic        rdy, en_st, pwr, rev, dyn, rel, eng, stp, ast;
  int          n;
  int          err_count = 0;
  int          samples_checked = 0;

  sss_stop_seq #(.TICK_CYC(TCK)) sss_stop_seq_i (.CLK_SYS_I(clk), .RST_I(rst),
    .INIT_DONE_I(ini), .MAIN_POWER_OK_I(mpw), .ENABLE_I(ena), .ALARM_I(alm),
    .DISABLE_STOP_SELECT_I(dsel), .ALARM_STOP_SELECT_I(asel), .STOP_TORQUE_LIMIT_I(TQ),
    .STOP_TIME_LIMIT_I(TLIM), .STOP_SPEED_THRESHOLD_I(16'h0064), .MOTOR_SPEED_I(spd),
    .SERVO_READY_STATUS_O(rdy), .SERVO_ENABLED_STATUS_O(en_st), .POWER_ON_O(pwr),
    .REVERSE_BRAKE_O(rev), .TORQUE_LIMIT_O(tq), .DYN_BRAKE_O(dyn),
    .BRAKE_RELEASE_SIGNAL_O(rel), .BRAKE_ENGAGE_SIGNAL_O(eng), .STOPPING_O(stp),
    .ALARM_STOP_O(ast));
  sss_motor_model sss_motor_model_i (.clk_i(clk), .rst_i(rst), .power_on_i(pwr),
    .reverse_brake_i(rev), .dyn_brake_i(dyn), .speed_o(spd));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk_bit(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %b", $time, what, got);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic end_of_test;
    $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // bounded wait for the end of decel, then back to idle
  task automatic wait_stop(output int c);
    c = 0;
    while (stp === 1'b1 && c < 200) begin
      cyc(1);
      c++;
    end
    chk_bit(dyn, 1'b0, "dyn after decel");
    chk_bit(eng, 1'b1, "engage after decel");
    chk_bit(pwr, 1'b0, "power after decel");
    ena = 1'b0;
    alm = 1'b0;
    cyc(3);
  endtask
  task automatic run_row(input logic [7:0] r);
    int c;
    ena = 1'b1;
    cyc(4);
    chk_bit(en_st, 1'b1, "enabled");
    chk_bit(rel, 1'b1, "release in run");
    // the unused select differs in method, so a wrong pick shows
    asel = r[7] ? r[6:3] : r[6:3] ^ 4'h4;
    dsel = r[7] ? r[6:3] ^ 4'h4 : r[6:3];
    alm = r[7];
    ena = r[7];
    cyc(1);
    chk_bit(stp, 1'b1, "stopping");
    chk_bit(ast, r[7], "alarm select");
    chk_bit(pwr, r[2], "power in decel");
    chk_bit(rev, r[1], "reverse brake");
    chk_bit(dyn, r[0], "dyn in decel");
    chk_word(tq, r[1] ? TQ : 16'h0000, "torque limit");
    wait_stop(c);
    if (r[1] || r[0]) begin
      chk_bit(c < TCK * TLIM, 1'b1, "end by speed");
    end else begin
      chk_bit(c >= TCK * TLIM - 2 && c <= TCK * TLIM + 3, 1'b1, "end by time");
    end
  endtask

  initial begin
    rst = 1'b1;
    ini = 1'b0;
    mpw = 1'b1;
    ena = 1'b0;
    alm = 1'b0;
    dsel = 4'h0;
    asel = 4'h0;
    cyc(10);
    chk_bit(eng, 1'b1, "engage in reset");
    rst = 1'b0;
    cyc(2);
    chk_bit(rdy, 1'b0, "ready before init");
    ini = 1'b1;
    cyc(2);
    chk_bit(rdy, 1'b1, "ready");
    foreach (ROWS[i]) begin
      run_row(ROWS[i]);
    end
    // alarm in mid coast takes over the rest of the stop
    dsel = 4'h2;
    asel = 4'h0;
    ena = 1'b1;
    cyc(4);
    ena = 1'b0;
    cyc(3);
    alm = 1'b1;
    cyc(1);
    chk_bit(rev, 1'b1, "swap to alarm method");
    chk_bit(ast, 1'b1, "alarm select on swap");
    wait_stop(n);
    mpw = 1'b0;
    cyc(1);
    ena = 1'b1;
    cyc(3);
    chk_bit(rdy, 1'b0, "ready no power");
    chk_bit(en_st, 1'b0, "refused not ready");
    alm = 1'b1;
    mpw = 1'b1;
    cyc(3);
    chk_bit(en_st, 1'b0, "refused in alarm");
    alm = 1'b0;
    cyc(3);
    chk_bit(en_st, 1'b1, "enabled when clear");
    mpw = 1'b0;
    cyc(2);
    chk_bit(ast, 1'b1, "power loss stop");
    wait_stop(n);
    mpw = 1'b1;
    ena = 1'b1;
    cyc(4);
    rst = 1'b1;
    cyc(1);
    chk_bit(eng, 1'b1, "engage on reset");
    chk_bit(en_st, 1'b0, "enabled on reset");
    rst = 1'b0;
    cyc(3);
    chk_bit(en_st, 1'b1, "enabled after reset");
    end_of_test();
  end
  initial begin
    cyc(5000);
    err_count++;
    end_of_test();
  end
endmodule
